//--- core/lcdcg_cfg.svh
`ifndef LCDCG_CFG_SVH
`define LCDCG_CFG_SVH
`define LCDCG_CMD_OFFSET 8'h22
`define LCDCG_CMD_ADDR 8'h24
`define LCDCG_CMD_CTRL_MASK 8'hFC
`define LCDCG_CMD_CTRL 8'h40
`define LCDCG_CMD_WR_INC 8'hC0
`define LCDCG_CMD_WR_DEC 8'hC2
`define LCDCG_CMD_WR_KEEP 8'hC4
`define LCDCG_CMD_AUTO_WR 8'hB0
`define LCDCG_CMD_AUTO_END 8'hB2
`define LCDCG_CMD_MODE_MASK 8'hF0
`define LCDCG_CMD_MODE 8'h80
`define LCDCG_CMD_DISP 8'h90
`define LCDCG_ROM_HALF 16'h0400
`define LCDCG_USER_FIRST 8'h80
`define LCDCG_OFFSET_RESET 5'h00
`define LCDCG_ROW_BYTES_RESET 8'h1E
`define LCDCG_FONT_RESET 4'h8
`endif

//--- core/lcdcg_pkg.sv
package lcdcg_pkg;
	typedef enum {LCDCG_IDLE, LCDCG_WAIT_LO, LCDCG_WAIT_HI, LCDCG_EXEC} lcdcg_state_e;
	typedef logic [15:0] lcdcg_addr_t;
endpackage

//--- core/lcdcg_glyph_addr.sv
`include "lcdcg_cfg.svh"
// Glyph lookup: picks the glyph source and forms the pattern byte address
module lcdcg_glyph_addr (
	input wire logic [4:0] offsetSel,
	input wire logic [7:0] charCode,
	input wire logic [2:0] lineScan,
	input wire logic romMode,
	output logic useRam,
	output lcdcg_pkg::lcdcg_addr_t glyphAddr
);
	assign glyphAddr = {offsetSel, charCode, lineScan};
	assign useRam = !romMode || (charCode >= `LCDCG_USER_FIRST);
endmodule

//--- core/lcdcg_cmd_core.sv
`include "lcdcg_cfg.svh"
// What this block does
// - Write-data with increment stores the byte then advances the pointer by one.
// - Glyph area is a 2 kbyte block chosen by five offset bits.
// - Offset value 11100 places glyph area at E000h through E7FFh.
// - With internal ROM glyphs, code 80h starts at block base plus 400h.
// - Text code 80h or above renders from user glyph memory.
// - Control words set bytes per row, fixing next-row start address.
// - Font width governs bit-to-pixel mapping for text and graphics.
// - Glyph row address is offset, code, then line scan.
// - ROM mode: codes below 80h are ROM; RAM-only mode: all RAM.
// - Command 24h takes low then high pointer byte.
// - Command 22h takes two data bytes, the second always 00h.
module lcdcg_cmd_core #(
	parameter int ADDR_W = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic hostWrite,
	input wire logic hostIsCmd,
	input wire logic [7:0] hostData,
	output logic ready,
	output logic memWrite,
	output logic [ADDR_W-1:0] memAddr,
	output logic [7:0] memData,
	output logic [4:0] offsetSel,
	output logic romMode,
	output logic textOn,
	output logic graphicsOn,
	output logic [7:0] rowBytes,
	output logic [3:0] fontWidth,
	output logic [15:0] textHome,
	output logic [15:0] graphicHome,
	output logic [15:0] rowStart,
	input wire logic [7:0] scanCode,
	input wire logic [2:0] scanLine,
	input wire logic [7:0] scanRow,
	output logic glyphFromRam,
	output logic [15:0] glyphAddr,
	output logic [2:0] pixelShift,
	output logic protoError
);
	// ----------------------------------------
	// Host byte interpreter
	// ----------------------------------------
	lcdcg_pkg::lcdcg_state_e state;
	logic [15:0] pointer;
	logic [7:0] arg0;
	logic [7:0] arg1;
	logic gotArg0;
	logic gotArg1;
	logic autoWrite;
	logic takeCmd;
	logic takeData;

	assign takeCmd = hostWrite && hostIsCmd && ready;
	assign takeData = hostWrite && !hostIsCmd && ready;
	// Busy for one cycle after every accepted byte so the host sees each one land
	assign ready = (state != lcdcg_pkg::LCDCG_EXEC);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= lcdcg_pkg::LCDCG_IDLE;
		end else if (state == lcdcg_pkg::LCDCG_EXEC) begin
			state <= lcdcg_pkg::LCDCG_IDLE;
		end else if (takeCmd || takeData) begin
			state <= lcdcg_pkg::LCDCG_EXEC;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			arg0 <= 8'h00;
			arg1 <= 8'h00;
			gotArg0 <= 1'b0;
			gotArg1 <= 1'b0;
		end else if (takeCmd) begin
			gotArg0 <= 1'b0;
			gotArg1 <= 1'b0;
		end else if (takeData && !autoWrite) begin
			if (!gotArg0) begin
				arg0 <= hostData;
				gotArg0 <= 1'b1;
			end else begin
				arg1 <= hostData;
				gotArg1 <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pointer <= 16'h0000;
			autoWrite <= 1'b0;
			offsetSel <= `LCDCG_OFFSET_RESET;
			romMode <= 1'b1;
			textOn <= 1'b0;
			graphicsOn <= 1'b0;
			rowBytes <= `LCDCG_ROW_BYTES_RESET;
			textHome <= 16'h0000;
			graphicHome <= 16'h0000;
			fontWidth <= `LCDCG_FONT_RESET;
			memWrite <= 1'b0;
			memAddr <= '0;
			memData <= 8'h00;
			protoError <= 1'b0;
		end else begin
			memWrite <= 1'b0;
			protoError <= 1'b0;
			if (takeData && autoWrite) begin
				memWrite <= 1'b1;
				memAddr <= pointer[ADDR_W-1:0];
				memData <= hostData;
				pointer <= pointer + 16'h0001;
			end else if (takeCmd) begin
				if (hostData == `LCDCG_CMD_AUTO_END) begin
					autoWrite <= 1'b0;
				end else if (hostData == `LCDCG_CMD_AUTO_WR) begin
					autoWrite <= 1'b1;
				end else if ((hostData & `LCDCG_CMD_MODE_MASK) == `LCDCG_CMD_MODE) begin
					romMode <= !hostData[3];
				end else if ((hostData & `LCDCG_CMD_MODE_MASK) == `LCDCG_CMD_DISP) begin
					textOn <= hostData[2];
					graphicsOn <= hostData[3];
				end else if (hostData == `LCDCG_CMD_WR_INC || hostData == `LCDCG_CMD_WR_DEC
					|| hostData == `LCDCG_CMD_WR_KEEP) begin
					// Single write takes its byte from the first data byte latched before the command
					memWrite <= 1'b1;
					memAddr <= pointer[ADDR_W-1:0];
					memData <= arg0;
					if (hostData == `LCDCG_CMD_WR_INC) begin
						pointer <= pointer + 16'h0001;
					end else if (hostData == `LCDCG_CMD_WR_DEC) begin
						pointer <= pointer - 16'h0001;
					end
				end else if (hostData == `LCDCG_CMD_ADDR) begin
					if (gotArg0 && gotArg1) begin
						pointer <= {arg1, arg0};
					end else begin
						protoError <= 1'b1;
					end
				end else if (hostData == `LCDCG_CMD_OFFSET) begin
					// A nonzero second byte is flagged but the offset still applies
					if (gotArg0 && gotArg1) begin
						offsetSel <= arg0[4:0];
					end
					protoError <= !(gotArg0 && gotArg1) || (arg1 != 8'h00);
				end else if ((hostData & `LCDCG_CMD_CTRL_MASK) == `LCDCG_CMD_CTRL) begin
					case (hostData[1:0])
						2'b00: textHome <= {arg1, arg0};
						2'b01: rowBytes <= arg0;
						2'b10: graphicHome <= {arg1, arg0};
						2'b11: rowBytes <= arg0;
						default: rowBytes <= rowBytes;
					endcase
				end else if (hostData[7:4] == 4'hF) begin
					fontWidth <= hostData[3:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Display scan addressing
	// ----------------------------------------
	logic [15:0] rowOffset;
	assign rowOffset = 16'(rowBytes * scanRow);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rowStart <= 16'h0000;
			pixelShift <= 3'h0;
		end else begin
			rowStart <= (textOn ? textHome : graphicHome) + rowOffset;
			pixelShift <= 3'(4'h8 - fontWidth);
		end
	end

	logic rawUseRam;
	logic [15:0] rawGlyphAddr;
	lcdcg_glyph_addr glyphLookup (
		.offsetSel(offsetSel),
		.charCode(scanCode),
		.lineScan(scanLine),
		.romMode(romMode),
		.useRam(rawUseRam),
		.glyphAddr(rawGlyphAddr)
	);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			glyphFromRam <= 1'b0;
			glyphAddr <= 16'h0000;
		end else begin
			glyphFromRam <= textOn && rawUseRam;
			glyphAddr <= rawGlyphAddr;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_busy_after_byte: assert property (@(posedge clock) disable iff (!reset_n)
		(takeCmd || takeData) |=> !ready) else $error("ready not dropped after byte");
	chk_inc_pointer: assert property (@(posedge clock) disable iff (!reset_n)
		(takeCmd && hostData == 8'hC0) |=> (memWrite && pointer == $past(pointer) + 16'h0001))
		else $error("write-increment did not advance");
	chk_offset_load: assert property (@(posedge clock) disable iff (!reset_n)
		(takeCmd && hostData == 8'h22 && gotArg0 && gotArg1) |=> offsetSel == $past(arg0[4:0]))
		else $error("offset not loaded");
	chk_offset_second: assert property (@(posedge clock) disable iff (!reset_n)
		(takeCmd && hostData == 8'h22 && gotArg0 && gotArg1 && arg1 != 8'h00) |=> protoError)
		else $error("bad second offset byte not flagged");
	chk_pointer_load: assert property (@(posedge clock) disable iff (!reset_n)
		(takeCmd && hostData == 8'h24 && gotArg0 && gotArg1) |=> pointer == {$past(arg1), $past(arg0)})
		else $error("pointer byte order wrong");
	chk_glyph_base: assert property (@(posedge clock) disable iff (!reset_n)
		(offsetSel == 5'h1C && scanCode == 8'h80 && scanLine == 3'h0) |=> glyphAddr == 16'hE400)
		else $error("glyph base wrong");
	chk_rom_split: assert property (@(posedge clock) disable iff (!reset_n)
		(textOn && romMode && scanCode < 8'h80) |=> !glyphFromRam) else $error("ROM code taken from RAM");
	chk_user_glyph: assert property (@(posedge clock) disable iff (!reset_n)
		(textOn && scanCode >= 8'h80) |=> glyphFromRam) else $error("user code not from RAM");
	chk_row_start: assert property (@(posedge clock) disable iff (!reset_n)
		(!textOn && $stable(rowBytes) && $stable(scanRow) && $stable(graphicHome))
		|=> rowStart == 16'($past(graphicHome) + 16'($past(rowBytes) * $past(scanRow))))
		else $error("row start wrong");
	cov_auto_write: cover property (@(posedge clock) disable iff (!reset_n) autoWrite && memWrite);
	cov_offset_set: cover property (@(posedge clock) disable iff (!reset_n) offsetSel == 5'h1C);
	cov_user_glyph: cover property (@(posedge clock) disable iff (!reset_n) glyphFromRam);
endmodule

//--- test/lcdcg_host.sv
// ----------------------------------------
// Host side of the byte port
// ----------------------------------------
module lcdcg_host (
	input wire logic clock,
	input wire logic ready,
	output logic hostWrite,
	output logic hostIsCmd,
	output logic [7:0] hostData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		hostWrite = 1'b0;
		hostIsCmd = 1'b0;
		hostData = 8'h00;
	end
	task automatic send(input logic isCmd, input logic [7:0] d);
		@(posedge clock);
		while (ready !== 1'b1) @(posedge clock);
		hostWrite <= 1'b1;
		hostIsCmd <= isCmd;
		hostData <= d;
		// Held until an edge samples ready high, so a refused byte is never lost
		do @(posedge clock); while (ready !== 1'b1);
		hostWrite <= 1'b0;
		// Released bus shows the inverse so a stale byte cannot pass
		hostData <= ~d;
	endtask
	// Arguments go low byte first, command last
	task automatic cmd2(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] c);
		send(1'b0, a0);
		send(1'b0, a1);
		send(1'b1, c);
	endtask
endmodule

//--- test/lcd_char_gen_display_memory_addressing_tb_top.sv
module lcd_char_gen_display_memory_addressing_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic hostWrite, hostIsCmd, ready, memWrite, romMode, textOn, graphicsOn, glyphFromRam, protoError;
	logic [7:0] hostData, memData, rowBytes;
	logic [7:0] scanCode = 8'h00;
	logic [7:0] scanRow = 8'h00;
	logic [2:0] scanLine = 3'h0;
	logic [15:0] memAddr, textHome, graphicHome, rowStart, glyphAddr;
	logic [4:0] offsetSel;
	logic [3:0] fontWidth;
	logic [2:0] pixelShift;
	logic [7:0] rnd = 8'h2B;
	logic [7:0] rowB;
	logic [15:0] home;
	int errPulses = 0;
	logic [23:0] expWrites[$];
	int error_cnt = 0;
	int num_checks = 0;
	int cycles = 0;
	always #20 clock = ~clock;
	lcdcg_host host (.clock(clock), .ready(ready), .hostWrite(hostWrite), .hostIsCmd(hostIsCmd),
		.hostData(hostData));
	lcdcg_cmd_core dut (.clock(clock), .reset_n(reset_n), .hostWrite(hostWrite), .hostIsCmd(hostIsCmd),
		.hostData(hostData), .ready(ready), .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
		.offsetSel(offsetSel), .romMode(romMode), .textOn(textOn), .graphicsOn(graphicsOn),
		.rowBytes(rowBytes), .fontWidth(fontWidth), .textHome(textHome), .graphicHome(graphicHome),
		.rowStart(rowStart), .scanCode(scanCode), .scanLine(scanLine), .scanRow(scanRow),
		.glyphFromRam(glyphFromRam), .glyphAddr(glyphAddr), .pixelShift(pixelShift),
		.protoError(protoError));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// Write monitor and watchdog
	// ----------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (protoError === 1'b1)
			errPulses++;
		if (memWrite === 1'b1) begin
			if (expWrites.size() == 0)
				chk("unexpected write", 24'h0, {memAddr, memData});
			else
				chk("write", expWrites.pop_front(), {memAddr, memData});
		end
		if (cycles > 20000) begin
			error_cnt++;
			conclude();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		chk("reset", {1'b1, 1'b1, 8'h1E, 4'h8, 5'h00},
			{ready, romMode, rowBytes, fontWidth, offsetSel});
		host.cmd2(8'h1C, 8'h00, 8'h22);
		@(posedge clock);
		#1;
		chk("offsetSel", 24'h1C, offsetSel);
		host.cmd2(8'h00, 8'hE4, 8'h24);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			expWrites.push_back({16'hE400 + 16'(i), rnd});
			host.send(1'b0, rnd);
			host.send(1'b1, 8'hC0);
		end
		// A pointer load with its bytes missing is flagged and leaves the pointer alone
		host.send(1'b1, 8'h24);
		repeat (2) @(posedge clock);
		chk("protoError count", 24'h1, 24'(errPulses));
		rnd = lfsr(rnd);
		expWrites.push_back({16'hE403, rnd});
		host.send(1'b0, rnd);
		host.send(1'b1, 8'hC4);
		rnd = lfsr(rnd);
		expWrites.push_back({16'hE403, rnd});
		host.send(1'b0, rnd);
		host.send(1'b1, 8'hC2);
		host.send(1'b1, 8'hB0);
		for (int k = 2; k < 4; k++) begin
			rnd = lfsr(rnd);
			expWrites.push_back({16'hE400 + 16'(k), rnd});
			host.send(1'b0, rnd);
		end
		host.send(1'b1, 8'hB2);
		rnd = lfsr(rnd);
		expWrites.push_back({16'hE404, rnd});
		host.send(1'b0, rnd);
		host.send(1'b1, 8'hC0);
		repeat (2) @(posedge clock);
		chk("pending writes", 24'h0, 24'(expWrites.size()));
		host.send(1'b1, 8'h94);
		for (int m = 0; m < 2; m++) begin
			host.send(1'b1, m ? 8'h88 : 8'h80);
			for (int c = 8'h7F; c < 8'h81; c++) begin
				@(posedge clock);
				rnd = lfsr(rnd);
				scanCode <= 8'(c);
				scanLine <= rnd[2:0];
				repeat (2) @(posedge clock);
				#1;
				chk("romMode", 24'(m == 0), romMode);
				chk("glyphFromRam", 24'(m == 1 || c >= 8'h80), glyphFromRam);
				chk("glyphAddr", {8'h00, 5'h1C, 8'(c), rnd[2:0]}, glyphAddr);
			end
		end
		// Text rows first, then graphic rows with text switched off
		for (int g = 0; g < 2; g++) begin
			rnd = lfsr(rnd);
			rowB = rnd;
			host.cmd2(rowB, 8'h00, g ? 8'h43 : 8'h41);
			rnd = lfsr(rnd);
			home = {rnd, lfsr(rnd)};
			host.cmd2(home[7:0], home[15:8], g ? 8'h42 : 8'h40);
			if (g == 1)
				host.send(1'b1, 8'h98);
			rnd = lfsr(lfsr(rnd));
			@(posedge clock);
			scanRow <= rnd;
			repeat (2) @(posedge clock);
			#1;
			chk("home", 24'(home), g ? graphicHome : textHome);
			chk("textOn graphicsOn", 24'(g ? 2'b01 : 2'b10), {textOn, graphicsOn});
			chk("rowStart", 24'(16'(home + 16'(rowB) * 16'(rnd))), rowStart);
		end
		chk("glyph with text off", 24'h0, glyphFromRam);
		host.send(1'b1, 8'hF6);
		repeat (2) @(posedge clock);
		#1;
		chk("fontWidth", 24'h6, fontWidth);
		chk("pixelShift", 24'h2, pixelShift);
		host.cmd2(8'h1C, 8'h05, 8'h22);
		repeat (2) @(posedge clock);
		chk("protoError count", 24'h2, 24'(errPulses));
		chk("offsetSel kept", 24'h1C, offsetSel);
		// Mid-run reset must bring ready, textOn, romMode, rowBytes, fontWidth and offsetSel back to their reset values
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		chk("reset again", {1'b1, 1'b0, 1'b1, 8'h1E, 4'h8, 5'h00},
			{ready, textOn, romMode, rowBytes, fontWidth, offsetSel});
		conclude();
	end
endmodule
